// file: spi_ctrl.v
// Serial peripheral interface: AHB-Lite registers, shifter, flags, halt.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "spi_defs.vh"
module spi_ctrl (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire        cpu_irq_mask,
	input  wire        cpu_halt,
	output wire        irq,
	output wire        wake_halt,
	input  wire        sck_in,
	output wire        sck_out,
	output wire        sck_oe,
	input  wire        mosi_in,
	output wire        mosi_out,
	output wire        mosi_oe,
	input  wire        miso_in,
	output wire        miso_out,
	output wire        miso_oe,
	input  wire        ss_n_in,
	output wire        pins_alt
);
	reg  [7:0] ctl;
	reg  [7:0] csr_cfg;
	reg        xfer_done;
	reg        write_collision_flag;
	reg        overrun_flag;
	reg        mode_fault_flag;
	reg        done_armed;
	reg        write_collision_flag_armed;
	reg        mode_fault_flag_armed;
	reg        wr_lock;
	reg  [7:0] shifter;
	reg  [3:0] edges;
	reg        busy;
	reg        sck_lvl;
	reg        sck_prev;
	reg        sampled;
	reg        a_valid;
	reg        a_write;
	reg  [3:0] a_addr;
	reg  [31:0] rdata;
	reg  [31:0] rdata_q;
	wire [7:0] rx_byte;
	wire       half_tick;
	wire       master;
	wire       enabled;
	wire       ss_int_n;
	wire       idle_lvl;
	wire       phase;
	wire       rd_data;
	wire       wr_data;
	wire       rd_csr;
	wire       wr_ctl;
	wire       wr_csr;
	wire       ser_in;
	wire       byte_done;
	wire       fault;
	wire       slv_edge;
	wire       frozen;
	reg  [7:0] next_shift;
	reg        next_sample;

	assign master   = ctl[`CTL_MASTER];
	assign enabled  = ctl[`CTL_SER_EN];
	assign idle_lvl = ctl[`CTL_IDLE_LVL];
	assign phase    = ctl[`CTL_PHASE];
	assign ss_int_n = csr_cfg[`CSR_SOFT_SEL] ? csr_cfg[`CSR_SOFT_LVL] :
		ss_n_in;
	assign frozen   = cpu_halt & master;
	assign fault    = enabled & master & ~ss_int_n;
	assign pins_alt = enabled;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_addr  <= 4'h0;
		end else if (hready) begin
			a_valid <= hsel & htrans[1];
			a_write <= hwrite;
			a_addr  <= haddr[3:0];
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	// Read data stand through the data phase, from the copy taken when
	// the address phase was accepted.
	assign hrdata    = rdata_q;
	assign rd_data = a_valid & ~a_write & (a_addr == `ADDR_DATA);
	assign wr_data = a_valid & a_write & (a_addr == `ADDR_DATA);
	assign rd_csr  = a_valid & ~a_write & (a_addr == `ADDR_CSTATUS);
	assign wr_csr  = a_valid & a_write & (a_addr == `ADDR_CSTATUS);
	assign wr_ctl  = a_valid & a_write & (a_addr == `ADDR_CONTROL);

	always @* begin
		rdata = 32'h0000_0000;
		if (hsel & htrans[1] & ~hwrite) begin
			case (haddr[3:0])
			`ADDR_DATA:    rdata = {24'h000000, rx_byte};
			`ADDR_CONTROL: rdata = {24'h000000, ctl};
			`ADDR_CSTATUS: rdata = {24'h000000, xfer_done, write_collision_flag, overrun_flag,
				mode_fault_flag, 1'b0, csr_cfg[2:0]};
			default:       rdata = 32'h0000_0000;
			endcase
		end
	end

	// The decode of an accepted address phase is held for its data phase.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_q <= 32'h0000_0000;
		else if (hready)
			rdata_q <= rdata;
	end

	wire data_ok = wr_data & ~busy & ~wr_lock;
	wire ctl_set_ok = ~mode_fault_flag | mode_fault_flag_armed;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl <= `CTL_RESET;
		end else if (fault) begin
			ctl[`CTL_SER_EN] <= 1'b0;
			ctl[`CTL_MASTER] <= 1'b0;
		end else if (wr_ctl & ~frozen) begin
			ctl <= hwdata[7:0];
			// Enable and master stay low while the fault flag waits
			// for its clearing sequence.
			if (!ctl_set_ok) begin
				ctl[`CTL_SER_EN] <= 1'b0;
				ctl[`CTL_MASTER] <= 1'b0;
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			csr_cfg <= `CSR_RESET;
		else if (wr_csr & ~frozen)
			csr_cfg <= {5'h00, hwdata[2:0]};
	end

	// A slave counts every level change of the clock pin while selected;
	// even counts lead and odd counts trail, whatever the idle level.
	assign slv_edge = enabled & ~master & ~ss_int_n & (sck_in != sck_prev);
	assign ser_in   = master ? miso_in : mosi_in;
	assign byte_done = busy & (edges == 4'd15) &
		(master ? (half_tick & ~frozen) : slv_edge);

	// The divider runs only while a master byte is in flight, so each
	// byte starts with a full half period.
	spi_rate_div u_div (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.run       (busy & master & ~frozen),
		.rate      ({ctl[`CTL_DIV2_EN_N], ctl[1:0]}),
		.half_tick (half_tick)
	);

	always @* begin
		next_shift  = shifter;
		next_sample = sampled;
		if (master ? (half_tick & ~frozen) : slv_edge) begin
			// With a late capture the first edge only launches the top
			// bit, which already stands on the pin, so nothing shifts.
			if (edges[0] == phase)
				next_sample = ser_in;
			else if (!(phase & (edges == 4'd0)))
				next_shift = {shifter[6:0], sampled};
		end
		if (byte_done & phase)
			next_shift = {shifter[6:0], next_sample};
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shifter  <= 8'h00;
			edges    <= 4'd0;
			busy     <= 1'b0;
			sck_lvl  <= 1'b0;
			sck_prev <= 1'b0;
			sampled  <= 1'b0;
		end else begin
			sck_prev <= sck_in;
			if (!enabled) begin
				busy    <= 1'b0;
				edges   <= 4'd0;
				sck_lvl <= idle_lvl;
			end else if (data_ok) begin
				shifter <= hwdata[7:0];
				busy    <= master;
				edges   <= 4'd0;
			end else if (busy | slv_edge) begin
				if (master ? (half_tick & ~frozen) : slv_edge) begin
					edges   <= edges + 4'd1;
					sck_lvl <= ~sck_lvl;
					sampled <= next_sample;
					shifter <= next_shift;
					if (!master)
						busy <= ~byte_done;
				end
				if (byte_done) begin
					busy    <= 1'b0;
					edges   <= 4'd0;
					sck_lvl <= idle_lvl;
				end
			end else begin
				sck_lvl <= idle_lvl;
			end
			if (!master & ss_int_n & ~busy)
				edges <= 4'd0;
		end
	end

	// The shifter keeps the received byte, so it is sent back next time.
	wire [7:0] done_byte = phase ? next_shift :
		{shifter[6:0], sampled};

	spi_rx_buffer u_rx (
		.hclk    (hclk),
		.hresetn (hresetn),
		.load    (byte_done),
		.din     (done_byte),
		.dout    (rx_byte)
	);

	// Every flag below lets its setting event win over a clear in the
	// same cycle, so no completion or error is lost.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xfer_done  <= 1'b0;
			overrun_flag        <= 1'b0;
			write_collision_flag       <= 1'b0;
			mode_fault_flag       <= 1'b0;
			done_armed <= 1'b0;
			write_collision_flag_armed <= 1'b0;
			mode_fault_flag_armed <= 1'b0;
			wr_lock    <= 1'b0;
		end else begin
			if (rd_csr & xfer_done)
				done_armed <= 1'b1;
			else if (rd_data | wr_data)
				done_armed <= 1'b0;
			if (byte_done)
				xfer_done <= 1'b1;
			else if (done_armed & (rd_data | wr_data))
				xfer_done <= 1'b0;
			if (byte_done & xfer_done)
				overrun_flag <= 1'b1;
			else if (rd_csr)
				overrun_flag <= 1'b0;
			if (byte_done)
				wr_lock <= 1'b1;
			else if (rd_csr)
				wr_lock <= 1'b0;
			if (rd_csr & write_collision_flag)
				write_collision_flag_armed <= 1'b1;
			else if (rd_data | wr_data)
				write_collision_flag_armed <= 1'b0;
			if (wr_data & busy)
				write_collision_flag <= 1'b1;
			else if (write_collision_flag_armed & (rd_data | wr_data))
				write_collision_flag <= 1'b0;
			if (rd_csr & mode_fault_flag)
				mode_fault_flag_armed <= 1'b1;
			else if (wr_ctl)
				mode_fault_flag_armed <= 1'b0;
			if (fault)
				mode_fault_flag <= 1'b1;
			else if (mode_fault_flag_armed & wr_ctl)
				mode_fault_flag <= 1'b0;
		end
	end

	// One shared request; only a slave completion also brings the processor out of wait.
	assign irq = ctl[`CTL_IRQ_EN] & ~cpu_irq_mask &
		(xfer_done | mode_fault_flag | overrun_flag);
	assign wake_halt = ctl[`CTL_IRQ_EN] & ~cpu_irq_mask & xfer_done &
		~master;

	// Between bytes the pin shows the configured idle level at once, so
	// turning on master mode never leaves a stale level for a cycle.
	assign sck_out  = master ? (busy ? sck_lvl : idle_lvl) :
		1'b0;
	assign sck_oe   = enabled & master;
	assign mosi_out = master ? shifter[7] : 1'b0;
	assign mosi_oe  = enabled & master & ~csr_cfg[`CSR_OUT_DIS];
	assign miso_out = master ? 1'b0 : shifter[7];
	assign miso_oe  = enabled & ~master & ~ss_int_n &
		~csr_cfg[`CSR_OUT_DIS];
endmodule // spi_ctrl

// file: spi_defs.vh
// Constants for the serial peripheral interface block.
`ifndef SPI_DEFS_VH
`define SPI_DEFS_VH
`define ADDR_DATA       4'h0
`define ADDR_CONTROL    4'h4
`define ADDR_CSTATUS    4'h8
`define CTL_IRQ_EN      7
`define CTL_SER_EN      6
`define CTL_DIV2_EN_N   5
`define CTL_MASTER      4
`define CTL_IDLE_LVL    3
`define CTL_PHASE       2
`define CSR_XFER_DONE   7
`define CSR_WRITE_COLLISION_FLAG        6
`define CSR_OVR         5
`define CSR_MODE_FAULT_FLAG        4
`define CSR_OUT_DIS     2
`define CSR_SOFT_SEL    1
`define CSR_SOFT_LVL    0
`define CTL_RESET       8'h00
`define CSR_RESET       8'h00
`define DIV_BITS        7
`endif

// file: spi_rate_div.v
// Master serial clock rate generator producing half-period enable pulses.
`timescale 1ns/1ps
module spi_rate_div (
	input  wire       hclk,
	input  wire       hresetn,
	input  wire       run,
	input  wire [2:0] rate,
	output reg        half_tick
);
	reg  [6:0] cnt;
	reg  [6:0] half_max;

	always @* begin
		case (rate)
		3'b100:  half_max = 7'd1;
		3'b000:  half_max = 7'd3;
		3'b001:  half_max = 7'd7;
		3'b110:  half_max = 7'd15;
		3'b010:  half_max = 7'd31;
		3'b011:  half_max = 7'd63;
		3'b101:  half_max = 7'd7;
		default: half_max = 7'd63;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 7'd0;
			half_tick <= 1'b0;
		end else if (!run) begin
			cnt <= 7'd0;
			half_tick <= 1'b0;
		end else if (cnt >= half_max) begin
			cnt <= 7'd0;
			half_tick <= 1'b1;
		end else begin
			cnt <= cnt + 7'd1;
			half_tick <= 1'b0;
		end
	end
endmodule // spi_rate_div

// file: spi_rx_buffer.v
// Receive buffer register that software reads in place of the shifter.
`timescale 1ns/1ps
module spi_rx_buffer (
	input  wire       hclk,
	input  wire       hresetn,
	input  wire       load,
	input  wire [7:0] din,
	output reg  [7:0] dout
);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dout <= 8'h00;
		else if (load)
			dout <= din;
	end
endmodule // spi_rx_buffer

// file: spi_ctrl_sva.sv
// Port-level assertions for the serial interface block.
`timescale 1ns/1ps
module spi_ctrl_sva (
	input wire        hclk,
	input wire        hresetn,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        cpu_irq_mask,
	input wire        cpu_halt,
	input wire        irq,
	input wire        wake_halt,
	input wire        sck_out,
	input wire        sck_oe,
	input wire        mosi_oe,
	input wire        miso_oe,
	input wire        pins_alt
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_irq_masked: assert property (cpu_irq_mask |-> !irq)
		else $error("irq raised while masked");
	a_sck_alt: assert property (sck_oe |-> pins_alt)
		else $error("clock driven outside serial mode");
	a_mosi_master: assert property (mosi_oe |-> sck_oe)
		else $error("mosi driven outside master mode");
	a_miso_slave: assert property (miso_oe |-> pins_alt && !sck_oe)
		else $error("miso driven outside slave mode");
	a_gpio_quiet: assert property (!pins_alt |-> !(sck_oe || mosi_oe || miso_oe))
		else $error("pin driven in general purpose mode");
	// One cycle of latency on the halt input is tolerated.
	a_halt_freeze: assert property (cpu_halt[*3] |-> $stable(sck_out))
		else $error("clock moved during halt");
	a_sck_half: assert property (sck_oe && $changed(sck_out) |=> $stable(sck_out))
		else $error("clock half period below two cycles");
	a_wake_slave: assert property (wake_halt |-> irq && !sck_oe)
		else $error("halt wake request outside slave completion");
	a_resp_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	a_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	cover property (irq);
	cover property (cpu_halt && sck_oe);
	cover property ($fell(pins_alt));
endmodule // spi_ctrl_sva

// file: spi_far_slave.sv
// Behavioural far-side serial slave used by the bench.
`timescale 1ns/1ps
module spi_far_slave (
	input  wire        sck,
	input  wire        sel_n,
	input  wire        mosi,
	input  wire        clock_idle_level,
	input  wire        clock_capture_phase,
	input  wire [7:0]  reply,
	output logic       miso,
	output logic [7:0] got
);
	logic [7:0] sh;
	logic       first;
	initial miso = 1'b0;
	always @(negedge sel_n) begin
		sh = reply;
		miso = reply[7];
		first = 1'b1;
	end
	// A released line shows the inverse of its last value.
	always @(posedge sel_n) miso = ~miso;
	always @(sck) begin
		if (!sel_n) begin
			if ((sck != clock_idle_level) != clock_capture_phase) begin
				got = {got[6:0], mosi};
			end else if (clock_capture_phase && first) begin
				first = 1'b0;
			end else begin
				sh = {sh[6:0], 1'b0};
				miso = sh[7];
			end
		end
	end
endmodule // spi_far_slave

// file: spi_ctrl_tb.sv
// Self-checking bench for the serial interface block.
`timescale 1ns/1ps
module spi_ctrl_tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        mask = 1'b0;
	logic        halt = 1'b0;
	logic        ss_n = 1'b1;
	logic        fsel_n = 1'b1;
	logic        clock_idle_level = 1'b0;
	logic        clock_capture_phase = 1'b0;
	logic [7:0]  frep = 8'h0;
	logic        msck = 1'b0;
	logic        mdrv = 1'b1;
	logic [7:0]  sb;
	logic [31:0] rv;
	logic [2:0]  codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
	int          miscompares = 0;
	int          total_checks = 0;
	wire [31:0]  hrdata;
	wire [7:0]   fgot;
	wire         hreadyout, hresp, irq, sck_out, sck_oe, fmiso;
	wire         mosi_out, mosi_oe, miso_out, miso_oe, pins_alt, wake_halt;
	wire         sck = sck_oe ? sck_out : clock_idle_level ^ msck;
	wire         mosi = mosi_oe ? mosi_out : mdrv;
	wire         miso = miso_oe ? miso_out : fmiso;
	always #5 hclk = ~hclk;
	spi_ctrl i_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.cpu_irq_mask(mask), .cpu_halt(halt), .irq, .wake_halt,
		.sck_in(sck), .sck_out, .sck_oe, .mosi_in(mosi), .mosi_out,
		.mosi_oe, .miso_in(miso), .miso_out, .miso_oe, .ss_n_in(ss_n),
		.pins_alt
	);
	spi_far_slave i_far (
		.sck, .sel_n(fsel_n), .mosi, .clock_idle_level, .clock_capture_phase, .reply(frep),
		.miso(fmiso), .got(fgot)
	);
	task automatic chk(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// Waits for ready high at a rising edge; read data is kept from it.
	task automatic wait_rdy;
		logic rdy;
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			rv = hrdata;
			@(posedge hclk);
		end while (rdy !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [31:0] a,
			input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		hsel <= 1'b0;
		@(negedge hclk);
	endtask
	task automatic xfer(input int i);
		logic [7:0] ctl;
		logic [7:0] tx;
		logic       s;
		int         n;
		ctl = {~i[0], 1'b1, codes[i][2], 1'b1, i[1], i[0], codes[i][1:0]};
		tx = 8'ha5 ^ i[7:0];
		clock_idle_level = ctl[3];
		clock_capture_phase = ctl[2];
		frep = ~tx;
		bus(1, 32'h4, 32'h0);
		bus(1, 32'h4, {24'h0, ctl});
		chk("sck idle", sck_out, ctl[3]);
		@(posedge hclk);
		fsel_n <= 1'b0;
		bus(1, 32'h0, {24'h0, tx});
		s = sck_out;
		while (sck_out === s) @(negedge hclk);
		s = sck_out;
		n = 0;
		while (sck_out === s) begin
			@(negedge hclk);
			n++;
		end
		chk("half period", n, 2 << i);
		if (i == 5) begin
			@(posedge hclk);
			halt <= 1'b1;
			repeat (2) @(negedge hclk);
			s = sck_out;
			repeat (100) @(negedge hclk);
			chk("halt sck", sck_out, s);
			@(posedge hclk);
			halt <= 1'b0;
		end
		bus(1, 32'h0, 32'hff);
		do bus(0, 32'h8, 32'h0); while (rv[7] !== 1'b1);
		chk("status done", rv, 32'hc3);
		chk("irq", irq, ctl[7]);
		if (ctl[7]) begin
			@(posedge hclk);
			mask <= 1'b1;
			@(negedge hclk);
			chk("irq masked", irq, 0);
			@(posedge hclk);
			mask <= 1'b0;
		end
		bus(0, 32'h0, 32'h0);
		chk("rx byte", rv, {24'h0, ~tx});
		chk("far got", {24'h0, fgot}, {24'h0, tx});
		bus(0, 32'h8, 32'h0);
		chk("status clear", rv, 32'h3);
		@(posedge hclk);
		fsel_n <= 1'b1;
	endtask
	// Acts as an external master on the pins: leading edge first.
	task automatic sbyte(input logic [7:0] b, output logic [7:0] r);
		for (int k = 7; k >= 0; k--) begin
			@(posedge hclk);
			mdrv <= b[k];
			repeat (4) @(posedge hclk);
			r[k] = miso;
			msck <= 1'b1;
			repeat (4) @(posedge hclk);
			msck <= 1'b0;
		end
		repeat (4) @(posedge hclk);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, 32'h4, 32'h0);
		chk("control reset", rv, 32'h0);
		bus(0, 32'h8, 32'h0);
		chk("status reset", rv, 32'h0);
		bus(0, 32'hc, 32'h0);
		chk("unmapped", rv, 32'h0);
		chk("pins alt", pins_alt, 0);
		$display("test reset done");
		bus(1, 32'h8, 32'h3);
		for (int i = 0; i < 6; i++) xfer(i);
		$display("test rates done");
		bus(1, 32'h8, 32'h0);
		bus(1, 32'h4, 32'hd0);
		@(posedge hclk);
		ss_n <= 1'b0;
		repeat (3) @(negedge hclk);
		chk("fault alt", pins_alt, 0);
		chk("fault irq", irq, 1);
		bus(0, 32'h4, 32'h0);
		chk("fault ctl", rv, 32'h80);
		bus(0, 32'h8, 32'h0);
		chk("fault flag", rv, 32'h10);
		@(posedge hclk);
		ss_n <= 1'b1;
		bus(1, 32'h4, 32'h0);
		bus(0, 32'h8, 32'h0);
		chk("fault clear", rv, 32'h0);
		$display("test fault done");
		bus(1, 32'h8, 32'h2);
		bus(1, 32'h4, 32'h40);
		chk("slave drive", {sck_oe, miso_oe}, 2'h1);
		bus(1, 32'h8, 32'h6);
		chk("out disable", miso_oe, 0);
		bus(1, 32'h8, 32'h2);
		bus(1, 32'h4, 32'hc0);
		@(posedge hclk);
		halt <= 1'b1;
		sbyte(8'h3c, sb);
		chk("halt wake", wake_halt, 1);
		halt <= 1'b0;
		sbyte(8'hc3, sb);
		chk("shift back", sb, 8'h3c);
		bus(0, 32'h8, 32'h0);
		chk("overrun", rv, 32'ha2);
		bus(0, 32'h8, 32'h0);
		chk("overrun clear", rv, 32'h82);
		$display("test slave done");
		test_done;
	end
	initial begin
		repeat (40000) @(posedge hclk);
		miscompares++;
		test_done;
	end
endmodule // spi_ctrl_tb
bind spi_ctrl spi_ctrl_sva i_sva (
	.hclk, .hresetn, .hrdata, .hreadyout, .hresp, .cpu_irq_mask,
	.cpu_halt, .irq, .wake_halt, .sck_out, .sck_oe, .mosi_oe, .miso_oe,
	.pins_alt
);
